// file: core/pmta_pkg.sv
/*
  Constants, enumerations and carrier structs for the program memory
  table-access unit: register offsets, field positions, reset values,
  pointer update modes and the flash request bundle.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pmta_pkg;

  localparam int PTR_W    = 22;
  localparam int MEM_W    = 21;
  localparam int BYTE_W   = 8;
  localparam int UPPER_W  = 6;
  localparam int RADDR_W  = 3;
  localparam int WBLK_LSB = 3;
  localparam int EBLK_LSB = 6;
  localparam int WBLK_W   = PTR_W - WBLK_LSB;
  localparam int EBLK_W   = PTR_W - EBLK_LSB;

  localparam logic [RADDR_W-1:0] REG_LATCH  = 3'h0;
  localparam logic [RADDR_W-1:0] REG_UPPER  = 3'h1;
  localparam logic [RADDR_W-1:0] REG_HIGH   = 3'h2;
  localparam logic [RADDR_W-1:0] REG_LOW    = 3'h3;
  localparam logic [RADDR_W-1:0] REG_STATUS = 3'h4;

  localparam int STAT_BUSY  = 0;
  localparam int STAT_WRITE = 1;
  localparam int STAT_ALT   = 2;

  localparam logic [BYTE_W-1:0] LATCH_RST = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST   = 22'h000000;

  typedef enum logic [1:0] {
    PMTA_NOCHG,
    PMTA_POSTINC,
    PMTA_POSTDEC,
    PMTA_PREINC
  } pmta_mode_e;

  typedef enum logic [1:0] {
    PMTA_IDLE,
    PMTA_RD_REQ,
    PMTA_RD_CAP,
    PMTA_WR_REQ
  } pmta_state_e;

  typedef struct packed {
    logic [RADDR_W-1:0] addr;
    logic [BYTE_W-1:0]  wdata;
    logic               wr;
    logic               rd;
  } pmta_bus_s;

  typedef struct packed {
    logic              valid;
    logic              is_write;
    pmta_mode_e        mode;
    logic [BYTE_W-1:0] wdata;
  } pmta_op_s;

  typedef struct packed {
    logic              rd_req;
    logic              wr_req;
    logic [PTR_W-1:0]  addr;
    logic [BYTE_W-1:0] wdata;
    logic              prog_req;
    logic [WBLK_W-1:0] prog_block;
    logic              erase_req;
    logic [EBLK_W-1:0] erase_block;
  } pmta_flash_s;

endpackage : pmta_pkg

// file: core/pmta_ptr_step.sv
/*
  Pointer stepping for table operations: gives the transfer address and
  the pointer value left behind for each of the four update modes.
  Assumes the 22-bit pointer with its top bit selecting the alternate space.
*/
`timescale 1ns/1ns
module pmta_ptr_step (
  input  wire logic [pmta_pkg::PTR_W-1:0] ptr,
  input  wire pmta_pkg::pmta_mode_e       mode,
  output logic      [pmta_pkg::PTR_W-1:0] xfer_addr,
  output logic      [pmta_pkg::PTR_W-1:0] ptr_after
);

  // step within the low field only; the top bit rides along unchanged
  function automatic logic [pmta_pkg::PTR_W-1:0] step(
    input logic [pmta_pkg::PTR_W-1:0] p,
    input logic                       down
  );
    logic [pmta_pkg::MEM_W-1:0] low;
    low = p[pmta_pkg::MEM_W-1:0];
    if (down) begin
      low = low - 21'h000001;
    end else begin
      low = low + 21'h000001;
    end
    return {p[pmta_pkg::PTR_W-1], low};
  endfunction : step

  always_comb begin
    xfer_addr = ptr;
    ptr_after = ptr;
    case (mode)
      pmta_pkg::PMTA_NOCHG: begin
        ptr_after = ptr;
      end
      pmta_pkg::PMTA_POSTINC: begin
        ptr_after = step(ptr, 1'b0);
      end
      pmta_pkg::PMTA_POSTDEC: begin
        ptr_after = step(ptr, 1'b1);
      end
      default: begin
        ptr_after = step(ptr, 1'b0);
        xfer_addr = ptr_after;
      end
    endcase
  end

endmodule : pmta_ptr_step

// file: core/pmta_unit.sv
/*
  Table-access unit: byte latch and 22-bit program byte pointer that let
  the core move single bytes between flash program memory and data RAM,
  and that point timed block writes and block erases.
  Assumes a flash array that returns read data the cycle after a read
  request is seen, a processor that issues one table operation at a time
  while op_busy is low, and a register master with one-cycle strobes.
*/
// Added by the designer: strobed register access and the address map.
// What this block does
// - Byte latch in register space carries every table transfer byte.
// - Pointer is upper, high and low byte registers joined into 22 bits.
// - Low 21 pointer bits address program memory bytes, up to 2 Mbytes.
// - Top pointer bit selects identification and configuration space.
// - Automatic pointer steps change only the low 21 bits.
// - Table read uses all 22 pointer bits to pick the byte latched.
// - Timed write uses pointer bits 21:3 as 8-byte block; 2:0 ignored.
// - Erase uses pointer bits 21:6 as 64-byte block; 5:0 ignored.
// - Reads and writes take address from pointer, with four update modes.
// - Plain variants transfer without changing the pointer.
// - Post-increment transfers at pointer, then adds one.
// - Post-decrement transfers at pointer, then subtracts one.
// - Pre-increment adds one first, then transfers at new address.
`timescale 1ns/1ns
module pmta_unit (
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  input  wire pmta_pkg::pmta_bus_s            bus,
  output logic      [pmta_pkg::BYTE_W-1:0]    bus_rdata,
  input  wire pmta_pkg::pmta_op_s             op,
  output logic                                op_busy,
  output logic                                op_done,
  output logic      [pmta_pkg::BYTE_W-1:0]    op_rdata,
  input  wire logic                           prog_start,
  input  wire logic                           erase_start,
  input  wire logic [pmta_pkg::BYTE_W-1:0]    fl_rdata,
  output pmta_pkg::pmta_flash_s               fl,
  output logic      [pmta_pkg::PTR_W-1:0]     program_byte_pointer
);

  typedef struct packed {
    pmta_pkg::pmta_state_e          state;
    logic [pmta_pkg::PTR_W-1:0]     ptr;
    logic [pmta_pkg::BYTE_W-1:0]    latch;
    logic [pmta_pkg::BYTE_W-1:0]    rdata;
    logic                           busy;
    logic                           done;
    logic                           last_write;
    pmta_pkg::pmta_flash_s          fl;
  } pmta_core_s;

  pmta_core_s                    st_reg;
  pmta_core_s                    st_next;
  logic [pmta_pkg::PTR_W-1:0]    xfer_addr;
  logic [pmta_pkg::PTR_W-1:0]    ptr_after;

  pmta_ptr_step pmta_ptr_step_i (
    .ptr       (st_reg.ptr),
    .mode      (op.mode),
    .xfer_addr (xfer_addr),
    .ptr_after (ptr_after)
  );

  // pointer byte views, used by the register read path only
  function automatic logic [pmta_pkg::BYTE_W-1:0] ptr_byte(
    input logic [pmta_pkg::PTR_W-1:0]   p,
    input logic [pmta_pkg::RADDR_W-1:0] a
  );
    logic [pmta_pkg::BYTE_W-1:0] b;
    b = 8'h00;
    if (a == pmta_pkg::REG_UPPER) begin
      b = {2'b00, p[pmta_pkg::PTR_W-1:16]};
    end else if (a == pmta_pkg::REG_HIGH) begin
      b = p[15:8];
    end else if (a == pmta_pkg::REG_LOW) begin
      b = p[7:0];
    end
    return b;
  endfunction : ptr_byte

  function automatic logic is_ptr_reg(input logic [pmta_pkg::RADDR_W-1:0] a);
    return (a == pmta_pkg::REG_UPPER) || (a == pmta_pkg::REG_HIGH) ||
           (a == pmta_pkg::REG_LOW);
  endfunction : is_ptr_reg

  logic [pmta_pkg::BYTE_W-1:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[pmta_pkg::STAT_BUSY]  = st_reg.busy;
    status_byte[pmta_pkg::STAT_WRITE] = st_reg.last_write;
    status_byte[pmta_pkg::STAT_ALT]   = st_reg.ptr[pmta_pkg::PTR_W-1];
  end

  always_comb begin
    st_next              = st_reg;
    st_next.done         = 1'b0;
    st_next.fl.rd_req    = 1'b0;
    st_next.fl.wr_req    = 1'b0;
    st_next.fl.prog_req  = 1'b0;
    st_next.fl.erase_req = 1'b0;

    // table operation sequencing
    case (st_reg.state)
      pmta_pkg::PMTA_IDLE: begin
        if (op.valid) begin
          st_next.busy       = 1'b1;
          st_next.last_write = op.is_write;
          st_next.ptr        = ptr_after;
          st_next.fl.addr    = xfer_addr;
          if (op.is_write) begin
            st_next.latch     = op.wdata;
            st_next.fl.wdata  = op.wdata;
            st_next.fl.wr_req = 1'b1;
            st_next.done      = 1'b1;
            st_next.state     = pmta_pkg::PMTA_WR_REQ;
          end else begin
            st_next.fl.rd_req = 1'b1;
            st_next.state     = pmta_pkg::PMTA_RD_REQ;
          end
        end
      end
      pmta_pkg::PMTA_RD_REQ: begin
        st_next.state = pmta_pkg::PMTA_RD_CAP;
      end
      pmta_pkg::PMTA_RD_CAP: begin
        st_next.latch = fl_rdata;
        st_next.rdata = fl_rdata;
        st_next.done  = 1'b1;
        st_next.busy  = 1'b0;
        st_next.state = pmta_pkg::PMTA_IDLE;
      end
      pmta_pkg::PMTA_WR_REQ: begin
        st_next.busy  = 1'b0;
        st_next.state = pmta_pkg::PMTA_IDLE;
      end
      default: begin
        st_next.busy  = 1'b0;
        st_next.state = pmta_pkg::PMTA_IDLE;
      end
    endcase

    // block write and erase take their block from the current pointer
    if (prog_start) begin
      st_next.fl.prog_req   = 1'b1;
      st_next.fl.prog_block = st_reg.ptr[pmta_pkg::PTR_W-1:pmta_pkg::WBLK_LSB];
    end
    if (erase_start) begin
      st_next.fl.erase_req   = 1'b1;
      st_next.fl.erase_block = st_reg.ptr[pmta_pkg::PTR_W-1:pmta_pkg::EBLK_LSB];
    end

    // software writes land last, so they win over a same-cycle pointer step
    if (bus.wr) begin
      if (bus.addr == pmta_pkg::REG_LATCH) begin
        st_next.latch = bus.wdata;
      end else if (bus.addr == pmta_pkg::REG_UPPER) begin
        st_next.ptr[pmta_pkg::PTR_W-1:16] = bus.wdata[pmta_pkg::UPPER_W-1:0];
      end else if (bus.addr == pmta_pkg::REG_HIGH) begin
        st_next.ptr[15:8] = bus.wdata;
      end else if (bus.addr == pmta_pkg::REG_LOW) begin
        st_next.ptr[7:0] = bus.wdata;
      end
    end
  end

  // register read data stand for exactly the cycle after the strobe
  logic [pmta_pkg::BYTE_W-1:0] bus_rdata_next;

  always_comb begin
    bus_rdata_next = 8'h00;
    if (bus.rd) begin
      if (bus.addr == pmta_pkg::REG_LATCH) begin
        bus_rdata_next = st_reg.latch;
      end else if (is_ptr_reg(bus.addr)) begin
        bus_rdata_next = ptr_byte(st_reg.ptr, bus.addr);
      end else if (bus.addr == pmta_pkg::REG_STATUS) begin
        bus_rdata_next = status_byte;
      end else begin
        bus_rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg.state          <= pmta_pkg::PMTA_IDLE;
      st_reg.ptr            <= pmta_pkg::PTR_RST;
      st_reg.latch          <= pmta_pkg::LATCH_RST;
      st_reg.rdata          <= pmta_pkg::LATCH_RST;
      st_reg.busy           <= 1'b0;
      st_reg.done           <= 1'b0;
      st_reg.last_write     <= 1'b0;
      st_reg.fl             <= '0;
      bus_rdata             <= 8'h00;
    end else begin
      st_reg                <= st_next;
      bus_rdata             <= bus_rdata_next;
    end
  end

  assign op_busy              = st_reg.busy;
  assign op_done              = st_reg.done;
  assign op_rdata             = st_reg.rdata;
  assign fl                   = st_reg.fl;
  assign program_byte_pointer = st_reg.ptr;

endmodule : pmta_unit

// file: verification/pmta_flash_model.sv
/*
  Flash array model: answers a read request with a byte derived from
  the address on the next edge, and scrambles its data lines otherwise.
  Assumes the pmta_unit flash request bundle.
*/
`timescale 1ns/1ns
module pmta_flash_model (
  input  wire logic                  mclk,
  input  wire pmta_pkg::pmta_flash_s fl,
  output logic [7:0]                 fl_rdata
);
  always @(posedge mclk) begin
    if (fl.rd_req) begin
      fl_rdata <= fl.addr[7:0] ^ fl.addr[15:8] ^ {fl.addr[21], 2'h0, fl.addr[20:16]};
    end else begin
      // data not held outside the read slot
      fl_rdata <= ~fl_rdata;
    end
  end
endmodule : pmta_flash_model

// file: verification/pmta_unit_assertions.sv
/*
  Checker for pmta_unit: pointer stepping, block fields and strobes.
  Assumes it is bound to every pmta_unit instance.
*/
`timescale 1ns/1ns
module pmta_unit_chk (
  input wire logic                   mclk,
  input wire logic                   rstn,
  input wire pmta_pkg::pmta_bus_s    bus,
  input wire logic [7:0]             bus_rdata,
  input wire pmta_pkg::pmta_op_s     op,
  input wire logic                   op_busy,
  input wire logic                   op_done,
  input wire pmta_pkg::pmta_flash_s  fl,
  input wire logic                   prog_start,
  input wire logic                   erase_start,
  input wire logic [21:0]            program_byte_pointer
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic take;
  assign take = op.valid && !op_busy && !bus.wr;
  sequence rd_walk;
    fl.rd_req ##1 !fl.rd_req && op_busy ##1 op_done && !op_busy;
  endsequence
  a_read_walk: assert property (
    take && !op.is_write |=> rd_walk) else $error("read sequence broken");
  a_write_done: assert property (
    take && op.is_write |=> fl.wr_req && op_done && fl.wdata == $past(op.wdata))
    else $error("write transfer broken");
  a_plain_hold: assert property (
    take && op.mode == pmta_pkg::PMTA_NOCHG |=> $stable(program_byte_pointer)
    && fl.addr == $past(program_byte_pointer)) else $error("plain op moved pointer");
  a_post_inc: assert property (
    take && op.mode == pmta_pkg::PMTA_POSTINC |=> fl.addr == $past(program_byte_pointer)
    && program_byte_pointer[20:0] == $past(program_byte_pointer[20:0]) + 21'h1)
    else $error("post increment wrong");
  a_post_dec: assert property (
    take && op.mode == pmta_pkg::PMTA_POSTDEC |=> fl.addr == $past(program_byte_pointer)
    && program_byte_pointer[20:0] == $past(program_byte_pointer[20:0]) - 21'h1)
    else $error("post decrement wrong");
  a_pre_inc: assert property (
    take && op.mode == pmta_pkg::PMTA_PREINC |=> fl.addr == program_byte_pointer
    && program_byte_pointer[20:0] == $past(program_byte_pointer[20:0]) + 21'h1)
    else $error("pre increment wrong");
  a_top_kept: assert property (
    take |=> $stable(program_byte_pointer[21])) else $error("step changed top bit");
  a_prog_block: assert property (
    prog_start |=> fl.prog_req && fl.prog_block == $past(program_byte_pointer[21:3]))
    else $error("write block wrong");
  a_erase_block: assert property (
    erase_start |=> fl.erase_req && fl.erase_block == $past(program_byte_pointer[21:6]))
    else $error("erase block wrong");
  a_rdata_idle: assert property (
    !bus.rd |=> bus_rdata == 8'h00) else $error("read data outside slot");
endmodule : pmta_unit_chk

bind pmta_unit pmta_unit_chk pmta_unit_chk_i (.mclk, .rstn, .bus, .bus_rdata, .op,
  .op_busy, .op_done, .fl, .prog_start, .erase_start, .program_byte_pointer);

// file: verification/pmta_unit_tb.sv
/*
  Testbench for pmta_unit: register access, every table op mode, the
  three stepping modes at pointer boundaries, block triggers.
  Assumes pmta_flash_model on the flash side.
*/
`timescale 1ns/1ns
module pmta_unit_tb;
  logic                  mclk;
  logic                  rstn;
  logic                  prog_start;
  logic                  erase_start;
  logic [7:0]            bus_rdata;
  logic [7:0]            op_rdata;
  logic [7:0]            fl_rdata;
  logic                  op_busy;
  logic                  op_done;
  logic [21:0]           program_byte_pointer;
  logic [21:0]           p;
  logic [21:0]           a;
  logic [21:0]           e;
  pmta_pkg::pmta_bus_s   bus;
  pmta_pkg::pmta_op_s    op;
  pmta_pkg::pmta_flash_s fl;
  int                    fail_count = 0;
  int                    total_checks = 0;
  int                    cycles = 0;
  logic [21:0]           starts [4] = '{22'h155AA3, 22'h1FFFFF, 22'h200000, 22'h3FFFFF};

  pmta_unit pmta_unit_i (.mclk, .rstn, .bus, .bus_rdata, .op, .op_busy, .op_done,
    .op_rdata, .prog_start, .erase_start, .fl_rdata, .fl, .program_byte_pointer);
  pmta_flash_model pmta_flash_model_i (.mclk, .fl, .fl_rdata);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [21:0] step(input logic [21:0] q, input logic [20:0] d);
    return {q[21], q[20:0] + d};
  endfunction : step

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] ad, input logic [7:0] e);
    @(posedge mclk);
    bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 check(bus_rdata, e);
  endtask : reg_rd

  task automatic do_op(input logic w, input pmta_pkg::pmta_mode_e m, input logic [7:0] d);
    int n = 0;
    @(posedge mclk);
    op <= '{valid: 1'b1, is_write: w, mode: m, wdata: d};
    @(posedge mclk);
    op.valid <= 1'b0;
    #1;
    while (op_done !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(op_done, 24'h000001);
  endtask : do_op

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    bus = '0;
    op = '0;
    prog_start = 1'b0;
    erase_start = 1'b0;
    rstn = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    for (int r = 0; r < 8; r++) reg_rd(r[2:0], 8'h00);
    reg_wr(3'h5, 8'hFF);
    reg_rd(3'h5, 8'h00);
    reg_wr(3'h1, 8'hFF);
    reg_rd(3'h1, 8'h3F);
    for (int w = 0; w < 2; w++) begin
      for (int m = 0; m < 4; m++) begin
        p = starts[m];
        reg_wr(3'h1, {2'h0, p[21:16]});
        reg_wr(3'h2, p[15:8]);
        reg_wr(3'h3, p[7:0]);
        do_op(w[0], pmta_pkg::pmta_mode_e'(m[1:0]), 8'hA0 + m[7:0]);
        a = (m == 3) ? step(p, 21'h1) : p;
        e = (m == 0) ? p : step(p, m == 2 ? 21'h1FFFFF : 21'h1);
        check(fl.addr, a);
        check(program_byte_pointer, e);
        if (w == 1) begin
          check(fl.wdata, 8'hA0 + m[7:0]);
          reg_rd(3'h0, 8'hA0 + m[7:0]);
        end else begin
          check(op_rdata, a[7:0] ^ a[15:8] ^ {a[21], 2'h0, a[20:16]});
          reg_rd(3'h0, a[7:0] ^ a[15:8] ^ {a[21], 2'h0, a[20:16]});
        end
        reg_rd(3'h3, e[7:0]);
        reg_rd(3'h2, e[15:8]);
        reg_rd(3'h1, {2'h0, e[21:16]});
        reg_rd(3'h4, {5'h00, e[21], w[0], 1'b0});
      end
    end
    reg_wr(3'h1, 8'h2A);
    reg_wr(3'h2, 8'hBC);
    reg_wr(3'h3, 8'hDE);
    @(posedge mclk);
    prog_start <= 1'b1;
    erase_start <= 1'b1;
    @(posedge mclk);
    prog_start <= 1'b0;
    erase_start <= 1'b0;
    #1 check(fl.prog_block, 22'h2ABCDE >> 3);
    check(fl.erase_block, 22'h2ABCDE >> 6);
    tally_and_finish();
  end
endmodule : pmta_unit_tb
